// [rtl/tstc_divider.sv]
// Purpose: Divides an enable-style source tick by a programmable ratio
// Assumes: Source ticks are one-cycle pulses synchronous to clk
// Notes: Ratio is code plus one; code 0 passes every tick through
`timescale 1ns/10ps
module tstc_divider #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic src_tick,
  input wire logic [W-1:0] div_code,
  output logic seq_tick
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // ----------------------------------------------------------------
  // Tick counter
  // ----------------------------------------------------------------
  // Count source ticks, emit one tick per div_code+1 of them
  always_comb begin
    next_count = count;
    seq_tick = 1'b0;
    if (src_tick) begin
      if (count >= div_code) begin
        next_count = '0;
        seq_tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // tstc_divider

// [rtl/tstc_pkg.sv]
// Purpose: Constants for the trigger sequencer timing control block
// Assumes: One clock domain; plain register port with word indices
// Notes: Every offset, field position, reset value and count lives here
package tstc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 4'h3;
  localparam int DATA_W = 16;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CLKSEL_LSB = 13;
  localparam int CLKSEL_W = 3;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 5;
  localparam int PWD_LSB = 4;
  localparam int PWD_W = 4;
  localparam int WDT_LSB = 0;
  localparam int WDT_W = 3;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CONTROL_WMASK = 16'hFFF7;
  // Clock source codes
  localparam logic [2:0] SRC_PERIPH = 3'h0;
  localparam logic [2:0] SRC_OSC = 3'h1;
  localparam logic [2:0] SRC_CONV = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;
  localparam logic [2:0] SRC_TMR2 = 3'h4;
  localparam logic [2:0] SRC_TMR3 = 3'h5;
  // Watchdog: code 1 gives 8 clocks, doubling per step
  localparam int WDT_BASE_SHIFT = 2;
  localparam int WDT_CNT_W = 10;
  // ----------------------------------------------------------------
  // Status and command bits
  // ----------------------------------------------------------------
  localparam int ST_TIMEOUT = 0;
  localparam int ST_PULSE_DONE = 1;
  localparam int ST_W = 2;
  localparam int CMD_PULSE = 0;
  localparam int CMD_KICK = 1;
endpackage

// [rtl/tstc_top.sv]
// Purpose: Timing control register and its sequencer clock, pulse and watchdog
// Assumes: Source clocks arrive as one-cycle tick enables synchronous to clk
// Notes: Reserved source codes give no ticks; status bits clear by writing one
`timescale 1ns/10ps
module tstc_top #(
  parameter int NUM_TRIG = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [tstc_pkg::ADDR_W-1:0] addr,
  input wire logic [tstc_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [tstc_pkg::DATA_W-1:0] rdata,
  input wire logic peripheral_clock,
  input wire logic oscillator_clock,
  input wire logic converter_conversion_clock,
  input wire logic timer_one_clock,
  input wire logic timer_two_clock,
  input wire logic timer_three_clock,
  input wire logic [NUM_TRIG-1:0] trig_request,
  output logic [NUM_TRIG-1:0] trig_out,
  output logic seq_tick,
  output logic watchdog_timeout,
  output logic irq
);
  import tstc_pkg::*;

  initial begin
    if (NUM_TRIG < 1 || NUM_TRIG > 14) begin
      $error("NUM_TRIG must be 1 to 14");
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] next_control;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] next_mask;
  logic [DATA_W-1:0] next_rdata;
  logic [CLKSEL_W-1:0] sequencer_clock_select;
  logic [DIV_W-1:0] sequencer_clock_divider;
  logic [PWD_W-1:0] trigger_pulse_width;
  logic [WDT_W-1:0] sequencer_watchdog_timeout;
  logic src_tick;
  logic cmd_kick;
  logic pulse_done;

  assign sequencer_clock_select = control[CLKSEL_LSB +: CLKSEL_W];
  assign sequencer_clock_divider = control[DIV_LSB +: DIV_W];
  assign trigger_pulse_width = control[PWD_LSB +: PWD_W];
  assign sequencer_watchdog_timeout = control[WDT_LSB +: WDT_W];
  assign cmd_kick = wr_en && addr == OFS_COMMAND && wdata[CMD_KICK];

  // Register writes and read mux; status set beats write-one-clear
  always_comb begin
    next_control = control;
    next_mask = mask;
    next_status = status;
    next_rdata = '0;
    if (wr_en) begin
      case (addr)
        OFS_CONTROL: next_control = wdata & CONTROL_WMASK;
        OFS_MASK: next_mask = wdata[ST_W-1:0];
        OFS_STATUS: next_status = status & ~wdata[ST_W-1:0];
        default: ;
      endcase
    end
    if (watchdog_timeout) begin
      next_status[ST_TIMEOUT] = 1'b1;
    end
    if (pulse_done) begin
      next_status[ST_PULSE_DONE] = 1'b1;
    end
    if (rd_en) begin
      case (addr)
        OFS_CONTROL: next_rdata = control;
        OFS_STATUS: next_rdata = {{(DATA_W-ST_W){1'b0}}, status};
        OFS_MASK: next_rdata = {{(DATA_W-ST_W){1'b0}}, mask};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      control <= CONTROL_RESET;
      status <= '0;
      mask <= '0;
      rdata <= '0;
    end else begin
      control <= next_control;
      status <= next_status;
      mask <= next_mask;
      rdata <= next_rdata;
    end
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // Clock source select and divider
  // ----------------------------------------------------------------
  // Reserved codes yield no ticks, freezing the sequencer
  always_comb begin
    case (sequencer_clock_select)
      SRC_PERIPH: src_tick = peripheral_clock;
      SRC_OSC: src_tick = oscillator_clock;
      SRC_CONV: src_tick = converter_conversion_clock;
      SRC_TMR1: src_tick = timer_one_clock;
      SRC_TMR2: src_tick = timer_two_clock;
      SRC_TMR3: src_tick = timer_three_clock;
      default: src_tick = 1'b0;
    endcase
  end

  tstc_divider #(
    .W(DIV_W)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .src_tick(src_tick),
    .div_code(sequencer_clock_divider),
    .seq_tick(seq_tick)
  );

  // ----------------------------------------------------------------
  // Trigger pulse generator
  // ----------------------------------------------------------------
  logic [NUM_TRIG-1:0] next_trig_out;
  logic [PWD_W-1:0] pulse_cnt;
  logic [PWD_W-1:0] next_pulse_cnt;

  // A request starts a shared pulse; width counted in sequencer ticks
  always_comb begin
    next_trig_out = trig_out;
    next_pulse_cnt = pulse_cnt;
    pulse_done = 1'b0;
    if (|trig_out) begin
      if (seq_tick) begin
        if (pulse_cnt == trigger_pulse_width) begin
          next_trig_out = '0;
          pulse_done = 1'b1;
        end else begin
          next_pulse_cnt = pulse_cnt + 1'b1;
        end
      end
    end else if (seq_tick && |trig_request) begin
      next_trig_out = trig_request;
      next_pulse_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trig_out <= '0;
      pulse_cnt <= '0;
    end else begin
      trig_out <= next_trig_out;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer watchdog
  // ----------------------------------------------------------------
  logic [WDT_CNT_W-1:0] wdt_cnt;
  logic [WDT_CNT_W-1:0] next_wdt_cnt;
  logic [WDT_CNT_W-1:0] wdt_limit;
  logic next_timeout;

  // Limit is 2^(code+2); the counter restarts on a kick or while the code is 0
  assign wdt_limit = WDT_CNT_W'(1) << (sequencer_watchdog_timeout + WDT_BASE_SHIFT);

  always_comb begin
    next_wdt_cnt = wdt_cnt;
    next_timeout = 1'b0;
    if (sequencer_watchdog_timeout == '0 || cmd_kick) begin
      next_wdt_cnt = '0;
    end else if (seq_tick) begin
      if (wdt_cnt + 1'b1 >= wdt_limit) begin
        next_wdt_cnt = '0;
        next_timeout = 1'b1;
      end else begin
        next_wdt_cnt = wdt_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdt_cnt <= '0;
      watchdog_timeout <= 1'b0;
    end else begin
      wdt_cnt <= next_wdt_cnt;
      watchdog_timeout <= next_timeout;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [10:0] tick_since;
  // Reference tick count; a tick in the timeout cycle opens the next period
  always_ff @(posedge clk) begin
    if (!rstn || sequencer_watchdog_timeout == '0 || cmd_kick) begin
      tick_since <= '0;
    end else if (watchdog_timeout) begin
      tick_since <= {10'h000, seq_tick};
    end else if (seq_tick) begin
      tick_since <= tick_since + 1'b1;
    end
  end

  a_wdt_disabled: assert property (@(posedge clk) disable iff (!rstn)
    $past(sequencer_watchdog_timeout) == '0 && sequencer_watchdog_timeout == '0
      |-> !watchdog_timeout)
    else $error("watchdog fired while disabled");
  a_wdt_period: assert property (@(posedge clk) disable iff (!rstn)
    $rose(watchdog_timeout) && $stable(control) && !$past(cmd_kick)
      |-> $past(tick_since) + 11'h001 == {1'b0, wdt_limit})
    else $error("watchdog period wrong");
  a_wdt_bound: assert property (@(posedge clk) disable iff (!rstn)
    tick_since <= {1'b0, wdt_limit})
    else $error("watchdog overran its limit");
  a_src_reserved: assert property (@(posedge clk) disable iff (!rstn)
    sequencer_clock_select > SRC_TMR3 |-> !src_tick)
    else $error("reserved source produced ticks");
  a_src_timer3: assert property (@(posedge clk) disable iff (!rstn)
    sequencer_clock_select == SRC_TMR3 |-> src_tick == timer_three_clock)
    else $error("timer three source not routed");
  a_div_by_one: assert property (@(posedge clk) disable iff (!rstn)
    sequencer_clock_divider == '0 |-> seq_tick == src_tick)
    else $error("divide by one not transparent");
  a_div_gap: assert property (@(posedge clk) disable iff (!rstn)
    seq_tick && sequencer_clock_divider == 5'h01 && $stable(control)
      |=> !seq_tick)
    else $error("divide by two ticked twice in a row");
  a_pulse_hold: assert property (@(posedge clk) disable iff (!rstn)
    |trig_out && pulse_cnt < trigger_pulse_width |=> trig_out == $past(trig_out))
    else $error("trigger pulse ended early");
  a_pulse_end: assert property (@(posedge clk) disable iff (!rstn)
    pulse_done |=> trig_out == '0)
    else $error("trigger pulse did not end");
  a_reset_clear: assert property (@(posedge clk)
    !rstn |=> control == '0)
    else $error("control not cleared by reset");

  c_timeout: cover property (@(posedge clk) disable iff (!rstn) watchdog_timeout);
  c_pulse: cover property (@(posedge clk) disable iff (!rstn) pulse_done);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
  c_wide: cover property (@(posedge clk) disable iff (!rstn)
    pulse_done && trigger_pulse_width == 4'hF);
endmodule // tstc_top

// [tb/testbench.sv]
// Purpose: Self-checking bench for the timing control register block
// Assumes: Source ticks held high act as a tick every cycle
// Notes: Every wait is bounded; a spent bound counts as a mismatch
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module testbench;
  import tstc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [5:0] src = 6'h00;
  logic [3:0] trig_request = 4'h0;
  logic [3:0] trig_out;
  logic seq_tick;
  logic watchdog_timeout;
  logic irq;
  int bad_count = 0;
  int n_checks = 0;
  int k;
  // Divider codes and pulse widths swept below
  logic [4:0] k_dv [4] = '{5'h01, 5'h03, 5'h1E, 5'h1F};
  logic [3:0] k_pw [3] = '{4'h0, 4'hE, 4'hF};
  // ------------------------------------------------------------
  // Clock and device
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  tstc_top #(.NUM_TRIG(4)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .peripheral_clock(src[0]),
    .oscillator_clock(src[1]), .converter_conversion_clock(src[2]),
    .timer_one_clock(src[3]), .timer_two_clock(src[4]), .timer_three_clock(src[5]),
    .trig_request(trig_request), .trig_out(trig_out), .seq_tick(seq_tick),
    .watchdog_timeout(watchdog_timeout), .irq(irq));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic setc(input logic [2:0] s, input logic [4:0] dv, input logic [3:0] pw,
                      input logic [2:0] wd);
    wr(OFS_CONTROL, {s, dv, pw, 1'b0, wd});
  endtask
  // Waits for a watchdog pulse (sel 0) or a trigger pulse (sel 1)
  task automatic await_sig(input int sel);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (((sel == 0) ? watchdog_timeout : (trig_out != 4'h0)) !== 1'b1 && k < 1100);
    if (k >= 1100) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Hang guard
  // ------------------------------------------------------------
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdchk(OFS_CONTROL, 16'h0000);
    `CHK(irq, 1'b0)
    wr(OFS_CONTROL, 16'hFFFF);
    rdchk(OFS_CONTROL, 16'hFFF7);
    rdchk(4'hF, 16'h0000);
    // Each source alone, then all others; reserved code 6 never ticks
    for (int c = 0; c < 7; c++) begin
      setc(c[2:0], 5'h00, 4'h0, 3'h0);
      @(posedge clk) src <= 6'h01 << c;
      @(negedge clk) `CHK(seq_tick, (c < 6))
      @(posedge clk) src <= ~(6'h01 << c);
      @(negedge clk) `CHK(seq_tick, 1'b0)
    end
    // A window of three periods holds three ticks whatever the phase
    @(posedge clk) src <= 6'h01;
    foreach (k_dv[i]) begin
      setc(3'h0, k_dv[i], 4'h0, 3'h0);
      repeat (70) @(negedge clk);
      k = 0;
      repeat ((k_dv[i] + 1) * 3) begin
        @(negedge clk);
        if (seq_tick === 1'b1) k++;
      end
      `CHK(k, 3)
    end
    // Pulse width with a tick every cycle; request dropped after capture
    wr(OFS_MASK, 16'h0002);
    foreach (k_pw[i]) begin
      setc(3'h0, 5'h00, k_pw[i], 3'h0);
      @(posedge clk) trig_request <= 4'hA;
      await_sig(1);
      `CHK(trig_out, 4'hA)
      k = 1;
      while (trig_out !== 4'h0 && k < 40) begin
        @(posedge clk) trig_request <= 4'h0;
        @(negedge clk) if (trig_out !== 4'h0) k++;
      end
      `CHK(k, k_pw[i] + 1)
      `CHK(irq, 1'b1)
      rdchk(OFS_STATUS, 16'h0002);
      wr(OFS_STATUS, 16'h0002);
      `CHK(irq, 1'b0)
    end
    // Disabled watchdog stays silent well past the longest timeout
    k = 0;
    repeat (600) begin
      @(negedge clk);
      if (watchdog_timeout !== 1'b0) k++;
    end
    `CHK(k, 0)
    rdchk(OFS_STATUS, 16'h0000);
    // Interval between successive timeouts for every nonzero code
    wr(OFS_MASK, 16'h0001);
    for (int w = 1; w < 8; w++) begin
      setc(3'h0, 5'h00, 4'h0, w[2:0]);
      await_sig(0);
      await_sig(0);
      `CHK(k, 1 << (w + 2))
    end
    `CHK(irq, 1'b1)
    setc(3'h0, 5'h00, 4'h0, 3'h0);
    rdchk(OFS_STATUS, 16'h0001);
    wr(OFS_MASK, 16'h0000);
    `CHK(irq, 1'b0)
    wr(OFS_MASK, 16'h0001);
    `CHK(irq, 1'b1)
    wr(OFS_STATUS, 16'h0001);
    `CHK(irq, 1'b0)
    // Kicks faster than the 8-tick limit hold the watchdog off, then it restarts
    setc(3'h0, 5'h00, 4'h0, 3'h1);
    await_sig(0);
    wr(OFS_STATUS, 16'h0001);
    repeat (6) wr(OFS_COMMAND, 16'h0002);
    rdchk(OFS_STATUS, 16'h0000);
    await_sig(0);
    `CHK(k, 6)
    conclude();
  end
endmodule // testbench
